//--- hdl/swc_sleep_wake_controller.sv
`timescale 1ns/1ps
// Overview of operation
// - Lockup taken in the non-maskable handler ignores further non-maskable interrupts.
// - Two sleep levels: normal sleep gating core clock, and deep sleep.
// - Deep sleep select bit chooses the sleep level on every entry.
// - Wait for interrupt enters sleep at once, unless the core is in lockup.
// - Wait for event sleeps if latch is 0, else clears latch and continues.
// - Wait for event path, both sleep and latch clear, is omitted in this configuration.
// - Latch set by external event, send event or, with event on new pending, a new pending interrupt; no software access.
// - Sleep on handler return sleeps when returning to thread mode.
// - Interrupt sleep wakes on exception of sufficient priority, enabled higher interrupt or debug wake.
// - With mask bit set, enabled higher interrupt wakes; entry waits for mask clear.
// - Event sleep wakes on sufficient exception or another core's send event.
// - Event on new pending makes any new pending interrupt wake the core from event sleep.
// - Sleep may be re-entered immediately after a spurious wake-up.
// - Sufficient priority means priority above the mask limit.
// - Lockup lasts until reset, debug halt, or non-maskable in hard fault.
module swc_sleep_wake_controller (
   input  wire logic               clk_i,
   input  wire logic               rst_b_i,
   input  wire swc_pkg::swc_ctrl_t ctrl_i,
   input  wire swc_pkg::swc_req_t  req_i,
   input  wire swc_pkg::swc_exc_t  exc_i,
   input  wire logic               interrupt_mask_bit_i,
   input  wire logic               ext_event_i,
   input  wire logic               send_event_instr_i,
   input  wire logic               debug_wake_i,
   output logic                    core_clk_en_o,
   output logic                    deep_sleep_o,
   output logic                    sleeping_o,
   output logic                    wait_event_skip_o,
   output logic                    exc_entry_allow_o,
   output logic                    lockup_o
);
   import swc_pkg::*;

   // Fields of the incoming carriers.
   wire logic  req_wait_interrupt;
   wire logic  req_wait_event;
   wire logic  req_return_thread;
   wire logic  ctl_event_on_pend;
   wire logic  ctl_deep_select;
   wire logic  ctl_exit_sleep;
   wire logic  exc_sufficient;
   wire logic  exc_higher_irq;
   wire logic  exc_new_pending;
   wire logic  exc_nmi;
   wire logic  exc_fault_nmi;
   wire logic  exc_fault_hard;
   wire logic  exc_debug_halt;

   assign req_wait_interrupt = req_i.wait_interrupt_instr;
   assign req_wait_event     = req_i.wait_event_instr;
   assign req_return_thread  = req_i.handler_return_thread;
   assign ctl_event_on_pend  = ctrl_i.event_on_new_pending;
   assign ctl_deep_select    = ctrl_i.deep_sleep_select;
   assign ctl_exit_sleep     = ctrl_i.sleep_on_handler_return;
   assign exc_sufficient     = exc_i.exc_sufficient;
   assign exc_higher_irq     = exc_i.irq_enabled_higher;
   assign exc_new_pending    = exc_i.new_pending;
   assign exc_nmi            = exc_i.nmi;
   assign exc_fault_nmi      = exc_i.fault_in_nmi;
   assign exc_fault_hard     = exc_i.fault_in_hardfault;
   assign exc_debug_halt     = exc_i.debug_halt;

   // Registered state and flags, their next values and the sleep target.
   swc_state_t state;
   swc_state_t next_state;
   swc_state_t sleep_target;
   logic       event_latch;
   logic       next_event_latch;
   logic       from_event;
   logic       next_from_event;
   logic       lockup;
   logic       next_lockup;
   logic       lockup_nmi;
   logic       next_lockup_nmi;
   logic       next_core_clk_en;
   logic       next_deep_sleep;
   logic       next_sleeping;
   logic       next_wait_event_skip;
   logic       next_exc_entry_allow;

   // Decoded conditions.
   wire logic  in_run;
   wire logic  asleep;
   wire logic  wait_event_req;
   wire logic  latch_is_clear;
   wire logic  latch_is_set;
   wire logic  wait_event_sleep;
   wire logic  wait_event_skip;
   wire logic  wait_interrupt_sleep;
   wire logic  exit_sleep;
   wire logic  sleep_req;
   wire logic  enter_sleep;
   wire logic  sleep_level;
   wire logic  event_in;
   wire logic  pend_event;
   wire logic  exc_wake;
   wire logic  event_wake;
   wire logic  spurious_wake;
   wire logic  wake;
   wire logic  latch_clear;
   wire logic  latch_set;
   wire logic  fault_lock;
   wire logic  lock_enter;
   wire logic  nmi_release;
   wire logic  lock_release;
   wire logic  lock_leave;
   wire logic  entry_ready;
   wire logic  entry_allow;

   // Sleep entry.
   assign in_run               = (state == SWC_RUN);
   assign asleep               = ~in_run;
   assign wait_event_req       = SWC_HAS_WAIT_EVENT & req_wait_event;
   assign latch_is_clear       = (event_latch == SWC_LATCH_CLEAR);
   assign latch_is_set         = (event_latch == SWC_LATCH_SET);
   assign wait_event_sleep     = wait_event_req & latch_is_clear;
   assign wait_event_skip      = wait_event_req & latch_is_set;
   assign wait_interrupt_sleep = req_wait_interrupt;
   assign exit_sleep           = ctl_exit_sleep & req_return_thread;
   assign sleep_req            = ~lockup & (wait_interrupt_sleep | wait_event_sleep | exit_sleep);
   assign enter_sleep          = in_run & sleep_req;
   assign sleep_level          = ctl_deep_select;
   assign sleep_target         = sleep_level ? SWC_DEEP : SWC_SLEEP;

   // Wake-up; the priority logic raises exc_sufficient only above the mask limit.
   assign event_in             = ext_event_i | send_event_instr_i;
   assign pend_event           = ctl_event_on_pend & exc_new_pending;
   assign exc_wake             = exc_sufficient | exc_higher_irq;
   assign event_wake           = from_event & (event_in | pend_event);
   assign spurious_wake        = debug_wake_i;
   assign wake                 = asleep & (exc_wake | event_wake | spurious_wake);

   // Event latch set and clear; a set in the same cycle wins.
   assign latch_clear          = wait_event_skip;
   assign latch_set            = event_in | pend_event;

   // Lockup.
   assign fault_lock           = exc_fault_nmi | exc_fault_hard;
   assign lock_enter           = ~lockup & fault_lock;
   assign nmi_release          = exc_nmi & ~lockup_nmi;
   assign lock_release         = exc_debug_halt | nmi_release;
   assign lock_leave           = lockup & lock_release;

   // Exception entry waits for a running clock and a clear mask bit.
   assign entry_ready          = in_run & ~lockup & exc_sufficient;
   assign entry_allow          = entry_ready & ~interrupt_mask_bit_i;

   // Next values of the outputs.
   assign next_core_clk_en     = (next_state == SWC_RUN);
   assign next_deep_sleep      = (next_state == SWC_DEEP);
   assign next_sleeping        = (next_state != SWC_RUN);
   assign next_wait_event_skip = wait_event_skip;
   assign next_exc_entry_allow = entry_allow;

   // Sleep on a taken request, run again on any wake source.
   always_comb begin
      next_state = state;
      unique case (state)
         SWC_RUN: begin
            if (enter_sleep) begin
               next_state = sleep_target;
            end
         end
         SWC_SLEEP, SWC_DEEP: begin
            if (wake) begin
               next_state = SWC_RUN;
            end
         end
         default: begin
            next_state = SWC_RUN;
         end
      endcase
   end

   // Remember whether the current sleep came from the wait-for-event path; a wake clears it.
   always_comb begin
      next_from_event = from_event;
      if (wake) begin
         next_from_event = SWC_FLAG_CLEAR;
      end else if (enter_sleep) begin
         next_from_event = wait_event_sleep;
      end
   end

   // One-bit event latch with no software path.
   always_comb begin
      next_event_latch = event_latch;
      if (latch_clear) begin
         next_event_latch = SWC_LATCH_CLEAR;
      end
      if (latch_set) begin
         next_event_latch = SWC_LATCH_SET;
      end
   end

   // Lockup holds until a release condition.
   always_comb begin
      next_lockup = lockup;
      if (lock_enter) begin
         next_lockup = SWC_FLAG_SET;
      end else if (lock_leave) begin
         next_lockup = SWC_FLAG_CLEAR;
      end
   end

   // Lockup taken in the non-maskable handler is marked so that no interrupt frees it.
   always_comb begin
      next_lockup_nmi = lockup_nmi;
      if (lock_enter) begin
         next_lockup_nmi = exc_fault_nmi;
      end else if (lock_leave) begin
         next_lockup_nmi = SWC_FLAG_CLEAR;
      end
   end

   // Each register below holds one state value, one flag or one output.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state <= SWC_STATE_RST;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         from_event <= SWC_FLAG_CLEAR;
      end else begin
         from_event <= next_from_event;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         event_latch <= SWC_LATCH_CLEAR;
      end else begin
         event_latch <= next_event_latch;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lockup <= SWC_FLAG_CLEAR;
      end else begin
         lockup <= next_lockup;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lockup_nmi <= SWC_FLAG_CLEAR;
      end else begin
         lockup_nmi <= next_lockup_nmi;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         core_clk_en_o <= SWC_CLK_EN_RST;
      end else begin
         core_clk_en_o <= next_core_clk_en;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         deep_sleep_o <= SWC_FLAG_CLEAR;
      end else begin
         deep_sleep_o <= next_deep_sleep;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sleeping_o <= SWC_FLAG_CLEAR;
      end else begin
         sleeping_o <= next_sleeping;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wait_event_skip_o <= SWC_FLAG_CLEAR;
      end else begin
         wait_event_skip_o <= next_wait_event_skip;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         exc_entry_allow_o <= SWC_FLAG_CLEAR;
      end else begin
         exc_entry_allow_o <= next_exc_entry_allow;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lockup_o <= SWC_FLAG_CLEAR;
      end else begin
         lockup_o <= next_lockup;
      end
   end

endmodule // swc_sleep_wake_controller

//--- hdl/swc_pkg.sv
package swc_pkg;

   // Run state and the two sleep levels.
   typedef enum logic [1:0] {
      SWC_RUN   = 2'b00,
      SWC_SLEEP = 2'b01,
      SWC_DEEP  = 2'b10
   } swc_state_t;

   // Wait-for-event path; this configuration leaves it out.
   localparam logic SWC_HAS_WAIT_EVENT = 1'b0;

   localparam logic SWC_LATCH_CLEAR = 1'b0;
   localparam logic SWC_LATCH_SET   = 1'b1;

   // Reset values of the state, the flags and the clock enable.
   localparam swc_state_t SWC_STATE_RST  = SWC_RUN;
   localparam logic       SWC_FLAG_CLEAR = 1'b0;
   localparam logic       SWC_FLAG_SET   = 1'b1;
   localparam logic       SWC_CLK_EN_RST = 1'b1;

   // Sleep control bits of the system control register.
   typedef struct packed {
      logic event_on_new_pending;
      logic deep_sleep_select;
      logic sleep_on_handler_return;
   } swc_ctrl_t;

   // Requests from the core pipeline, each a one-cycle pulse.
   typedef struct packed {
      logic wait_interrupt_instr;
      logic wait_event_instr;
      logic handler_return_thread;
   } swc_req_t;

   // Exception and lockup inputs from the priority logic.
   typedef struct packed {
      logic exc_sufficient;
      logic irq_enabled_higher;
      logic new_pending;
      logic nmi;
      logic fault_in_nmi;
      logic fault_in_hardfault;
      logic debug_halt;
   } swc_exc_t;

endpackage

//--- sim/swc_core_model.sv
`timescale 1ns/1ps
module swc_core_model (
   input  wire logic       pend_i,
   input  wire logic [1:0] prio_i,
   input  wire logic [1:0] limit_i,
   output logic            exc_sufficient_o
);
   // A pending exception only counts when it is above the mask limit.
   assign exc_sufficient_o = pend_i && (prio_i > limit_i);
endmodule // swc_core_model

//--- sim/swc_checker.sv
`timescale 1ns/1ps
module swc_checker (
   input logic               clk_i,
   input logic               rst_b_i,
   input swc_pkg::swc_ctrl_t ctrl_i,
   input swc_pkg::swc_req_t  req_i,
   input swc_pkg::swc_exc_t  exc_i,
   input logic               interrupt_mask_bit_i,
   input logic               debug_wake_i,
   input logic               core_clk_en_o,
   input logic               deep_sleep_o,
   input logic               sleeping_o,
   input logic               wait_event_skip_o,
   input logic               exc_entry_allow_o,
   input logic               lockup_o
);
   import swc_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   wire wk = exc_i.exc_sufficient | exc_i.irq_enabled_higher | debug_wake_i;
   wire ok = core_clk_en_o & !lockup_o & !wk;
   property p_wait_int; req_i.wait_interrupt_instr && ok |=> sleeping_o && !core_clk_en_o
      && deep_sleep_o == $past(ctrl_i.deep_sleep_select); endproperty
   a_wait_int: assert property (p_wait_int) else $error("no sleep");
   property p_soe; req_i.handler_return_thread && ctrl_i.sleep_on_handler_return && ok |=> sleeping_o; endproperty
   a_soe: assert property (p_soe) else $error("no exit sleep");
   property p_wake; sleeping_o && wk |=> core_clk_en_o && !sleeping_o; endproperty
   a_wake: assert property (p_wake) else $error("no wake");
   property p_stay; sleeping_o && !wk |=> sleeping_o && !core_clk_en_o; endproperty
   a_stay: assert property (p_stay) else $error("early wake");
   property p_wait_evt; req_i.wait_event_instr && !req_i.wait_interrupt_instr && core_clk_en_o
      && !req_i.handler_return_thread |=> core_clk_en_o && !wait_event_skip_o; endproperty
   a_wait_evt: assert property (p_wait_evt) else $error("event sleep");
   property p_clk_first; exc_entry_allow_o |-> core_clk_en_o && $past(core_clk_en_o); endproperty
   a_clk_first: assert property (p_clk_first) else $error("entry before clock");
   property p_mask; exc_entry_allow_o |-> $past(exc_i.exc_sufficient) && !$past(interrupt_mask_bit_i); endproperty
   a_mask: assert property (p_mask) else $error("entry masked");
   property p_nmi; exc_i.fault_in_nmi ##1 exc_i.nmi && !exc_i.debug_halt |=> lockup_o; endproperty
   a_nmi: assert property (p_nmi) else $error("nmi left lock");
   property p_dbg; lockup_o && exc_i.debug_halt |=> !lockup_o; endproperty
   a_dbg: assert property (p_dbg) else $error("lock kept");
endmodule // swc_checker
bind swc_sleep_wake_controller swc_checker swc_checker_i (.*);

//--- sim/tb_swc_sleep_wake_controller.sv
`timescale 1ns/1ps
module tb_swc_sleep_wake_controller;
   import swc_pkg::*;
   logic                  clk_i = 0, rst_b_i = 0, mb = 0, suf, pend = 0;
   logic [1:0]            prio = 0, lim = 1;
   swc_ctrl_t             ctrl = '0;
   logic [2:0]            req = '0;
   logic [8:0]            x = '0;
   logic [5:0]            o;
   int                    err_total = 0, n_compared = 0, cyc = 0;
   localparam logic [5:0] A = 6'h20, S = 6'h08, D = 6'h18, E = 6'h22, L = 6'h21;
   initial forever #10 clk_i = ~clk_i;
   swc_core_model swc_core_model_i (.pend_i(pend), .prio_i(prio), .limit_i(lim), .exc_sufficient_o(suf));
   swc_sleep_wake_controller swc_sleep_wake_controller_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .ctrl_i(ctrl),
      .req_i(swc_req_t'(req)), .exc_i(swc_exc_t'({suf, x[8:3]})), .interrupt_mask_bit_i(mb),
      .ext_event_i(x[1]), .send_event_instr_i(x[0]), .debug_wake_i(x[2]), .core_clk_en_o(o[5]),
      .deep_sleep_o(o[4]), .sleeping_o(o[3]), .wait_event_skip_o(o[2]), .exc_entry_allow_o(o[1]),
      .lockup_o(o[0]));
   task chk(input logic [5:0] e);
      n_compared++;
      if (o !== e) begin
         err_total++;
         $display("ERROR %0t got %h want %h", $time, o, e);
      end
   endtask
   task go(input logic [2:0] r, input logic [8:0] v, input logic [5:0] e);
      req = r;
      x = v;
      @(negedge clk_i);
      chk(e);
   endtask
   task tally_and_finish;
      if (err_total == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 500) begin
         err_total++;
         tally_and_finish;
      end
   end
   initial begin
      repeat (12) @(negedge clk_i);
      chk(A);
      rst_b_i = 1;
      go(0, 0, A);
      for (int d = 0; d < 2; d++) begin
         ctrl.deep_sleep_select = d[0];
         go(4, 0, d ? D : S);
         pend = 1;
         prio = 1;
         go(0, 0, d ? D : S);
         prio = 2;
         go(0, 0, A);
         go(0, 0, E);
         pend = 0;
         go(4, 0, d ? D : S);
         go(0, 9'h004, A);
      end
      ctrl = '0;
      mb = 1;
      go(4, 0, S);
      go(0, 9'h100, A);
      pend = 1;
      go(0, 0, A);
      mb = 0;
      go(0, 0, E);
      pend = 0;
      for (int s = 0; s < 2; s++) begin
         ctrl.sleep_on_handler_return = s[0];
         go(1, 0, s ? S : A);
         go(0, 9'h004, A);
      end
      ctrl = 3'h4;
      go(4, 0, S);
      go(0, 9'h083, S);
      go(0, 9'h004, A);
      go(2, 9'h003, A);
      go(0, 9'h020, L);
      go(0, 9'h040, L);
      go(4, 0, L);
      go(0, 9'h008, A);
      go(0, 9'h010, L);
      go(0, 9'h040, A);
      go(0, 0, A);
      tally_and_finish;
   end
endmodule // tb_swc_sleep_wake_controller
